// file: hdl/rtar_decoder.sv
// Purpose: decode and execute register-to-accumulator read instructions
// Assumes: one instruction word per cycle with instr_valid
// Notes:   accumulator value is held here and loaded per instruction
`timescale 1ns/100ps
module rtar_decoder
    import rtar_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           instr_valid,
    input  wire logic [IW-1:0]  instr_word,
    input  wire logic [DW-1:0]  acc_in,
    input  wire logic [DW-1:0]  clock_control_register,
    input  wire logic [DW-1:0]  resistor_enable_group_zero,
    input  wire logic [DW-1:0]  resistor_enable_group_one,
    input  wire logic [DW-1:0]  converter_control_one,
    input  wire logic [DW-1:0]  converter_control_two,
    input  wire logic [DW-1:0]  converter_control_three,
    input  wire logic [SPW-1:0] stack_pointer,
    input  wire logic [DW-1:0]  interrupt_enable_one,
    output logic      [DW-1:0]  acc_out,
    output logic                acc_write,
    output logic                instr_hit,
    output logic                carry_write,
    output logic                skip_write
);
    // ****************************************
    // decode
    // ****************************************
    function automatic logic [SEL_W:0] decode_op(input logic [IW-1:0] w);
        logic [SEL_W:0] r;
        r = '0;
        case (w)
            OP_READ_CLOCK_CONTROL:           r = {1'b1, SEL_CLK};
            OP_READ_RESISTOR_GROUP_ZERO:     r = {1'b1, SEL_PU0};
            OP_READ_RESISTOR_GROUP_ONE:      r = {1'b1, SEL_PU1};
            OP_READ_CONVERTER_CONTROL_ONE:   r = {1'b1, SEL_Q1};
            OP_READ_CONVERTER_CONTROL_TWO:   r = {1'b1, SEL_Q2};
            OP_READ_CONVERTER_CONTROL_THREE: r = {1'b1, SEL_Q3};
            OP_READ_STACK_POINTER:           r = {1'b1, SEL_SP};
            OP_READ_INTERRUPT_ENABLE_ONE:    r = {1'b1, SEL_V1};
            default:                         r = '0;
        endcase
        return r;
    endfunction

    logic [SEL_W:0]   dec;
    logic             hit;
    logic [SEL_W-1:0] sel;
    logic [DW-1:0]    rd_data;

    always_comb begin
        dec = decode_op(instr_word);
        hit = instr_valid & dec[SEL_W];
        sel = dec[SEL_W-1:0];
    end

    rtar_src_mux u_mux (
        .clk     (clk),
        .rst     (rst),
        .sel     (sel),
        .src_clk (clock_control_register),
        .src_pu0 (resistor_enable_group_zero),
        .src_pu1 (resistor_enable_group_one),
        .src_q1  (converter_control_one),
        .src_q2  (converter_control_two),
        .src_q3  (converter_control_three),
        .src_sp  (stack_pointer),
        .src_v1  (interrupt_enable_one),
        .rd_data (rd_data)
    );

    // ****************************************
    // execute
    // ****************************************
    rtar_state_t   state_reg;
    rtar_state_t   state_next;
    logic [DW-1:0] acc_reg;
    logic [DW-1:0] acc_next;
    logic          wr_reg;
    logic          wr_next;
    logic          hit_reg;

    always_comb begin
        state_next = state_reg;
        acc_next   = acc_reg;
        wr_next    = 1'b0;
        case (state_reg)
            RTAR_IDLE: begin
                if (hit) begin
                    state_next = RTAR_LOAD;
                end else begin
                    state_next = RTAR_PASS;
                    acc_next   = acc_in;
                end
            end
            RTAR_LOAD, RTAR_PASS: begin
                if (state_reg == RTAR_LOAD) begin
                    acc_next = rd_data;
                    wr_next  = 1'b1;
                end else begin
                    acc_next = acc_in;
                end
                state_next = hit ? RTAR_LOAD : RTAR_PASS;
            end
            default: state_next = RTAR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= RTAR_IDLE;
            acc_reg   <= ACC_RESET;
            wr_reg    <= 1'b0;
            hit_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_reg   <= acc_next;
            wr_reg    <= wr_next;
            hit_reg   <= hit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            carry_write <= 1'b0;
            skip_write  <= 1'b0;
        end else begin
            carry_write <= 1'b0;
            skip_write  <= 1'b0;
        end
    end

    assign acc_out   = acc_reg;
    assign acc_write = wr_reg;
    assign instr_hit = hit_reg;
endmodule

// file: include/rtar_pkg.sv
// Purpose: constants for the register-to-accumulator read decoder
// Assumes: 10-bit instruction words, 4-bit accumulator
// Notes:   opcodes, source select codes and state encodings used by the decoder
package rtar_pkg;
    localparam int IW = 10;
    localparam int DW = 4;
    localparam int SPW = 3;
    localparam logic [IW-1:0] OP_READ_CLOCK_CONTROL = 10'h252;
    localparam logic [IW-1:0] OP_READ_RESISTOR_GROUP_ZERO = 10'h257;
    localparam logic [IW-1:0] OP_READ_RESISTOR_GROUP_ONE = 10'h25E;
    localparam logic [IW-1:0] OP_READ_CONVERTER_CONTROL_ONE = 10'h244;
    localparam logic [IW-1:0] OP_READ_CONVERTER_CONTROL_TWO = 10'h245;
    localparam logic [IW-1:0] OP_READ_CONVERTER_CONTROL_THREE = 10'h246;
    localparam logic [IW-1:0] OP_READ_STACK_POINTER = 10'h050;
    localparam logic [IW-1:0] OP_READ_INTERRUPT_ENABLE_ONE = 10'h054;
    localparam logic [DW-1:0] ACC_RESET = 4'h0;
    localparam logic [DW-1:0] SRC_NONE = 4'h0;
    localparam logic SP_PAD = 1'b0;
    localparam int SRC_CNT = 8;
    localparam int SEL_W = 3;
    localparam logic [SEL_W-1:0] SEL_CLK = 3'h0;
    localparam logic [SEL_W-1:0] SEL_PU0 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_PU1 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_Q1 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_Q2 = 3'h4;
    localparam logic [SEL_W-1:0] SEL_Q3 = 3'h5;
    localparam logic [SEL_W-1:0] SEL_SP = 3'h6;
    localparam logic [SEL_W-1:0] SEL_V1 = 3'h7;
    typedef enum logic [2:0] {
        RTAR_IDLE = 3'b001,
        RTAR_LOAD = 3'b010,
        RTAR_PASS = 3'b100
    } rtar_state_t;
endpackage

// file: hdl/rtar_src_mux.sv
// Purpose: registered source selector for accumulator reads
// Assumes: sources sampled every cycle
// Notes:   read data come out of a register
`timescale 1ns/100ps
module rtar_src_mux
    import rtar_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic [DW-1:0]    src_clk,
    input  wire logic [DW-1:0]    src_pu0,
    input  wire logic [DW-1:0]    src_pu1,
    input  wire logic [DW-1:0]    src_q1,
    input  wire logic [DW-1:0]    src_q2,
    input  wire logic [DW-1:0]    src_q3,
    input  wire logic [SPW-1:0]   src_sp,
    input  wire logic [DW-1:0]    src_v1,
    output logic      [DW-1:0]    rd_data
);
    logic [DW-1:0] rd_reg;
    logic [DW-1:0] rd_next;

    always_comb begin
        case (sel)
            SEL_CLK: rd_next = src_clk;
            SEL_PU0: rd_next = src_pu0;
            SEL_PU1: rd_next = src_pu1;
            SEL_Q1:  rd_next = src_q1;
            SEL_Q2:  rd_next = src_q2;
            SEL_Q3:  rd_next = src_q3;
            SEL_SP:  rd_next = {SP_PAD, src_sp};
            SEL_V1:  rd_next = src_v1;
            default: rd_next = SRC_NONE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_reg <= SRC_NONE;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign rd_data = rd_reg;
endmodule

// file: tb/rtar_assertions.sv
// Purpose: port checks for the accumulator read decoder
// Assumes: one clock, sync reset
// Notes:   results land two edges after issue
`timescale 1ns/100ps
module rtar_checker
    import rtar_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           instr_valid,
    input wire logic [IW-1:0]  instr_word,
    input wire logic [DW-1:0]  acc_in,
    input wire logic [DW-1:0]  clock_control_register,
    input wire logic [SPW-1:0] stack_pointer,
    input wire logic [DW-1:0]  acc_out,
    input wire logic           acc_write,
    input wire logic           instr_hit,
    input wire logic           carry_write,
    input wire logic           skip_write
);
    logic hit_c;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign hit_c = instr_valid && (instr_word inside {OP_READ_CLOCK_CONTROL,
        OP_READ_RESISTOR_GROUP_ZERO, OP_READ_RESISTOR_GROUP_ONE,
        OP_READ_CONVERTER_CONTROL_ONE, OP_READ_CONVERTER_CONTROL_TWO,
        OP_READ_CONVERTER_CONTROL_THREE, OP_READ_STACK_POINTER,
        OP_READ_INTERRUPT_ENABLE_ONE});
    sequence s_issue(op);
        instr_valid && instr_word == op ##1 1'b1;
    endsequence
    clk_read_a: assert property (
        s_issue(OP_READ_CLOCK_CONTROL) |=> acc_write
        && acc_out == $past(clock_control_register, 2)) else $error("clk rd");
    sp_read_a: assert property (
        s_issue(OP_READ_STACK_POINTER) |=> acc_write
        && acc_out == $past({SP_PAD, stack_pointer}, 2)) else $error("sp rd");
    hit_time_a: assert property (
        hit_c |=> instr_hit) else $error("hit late");
    miss_quiet_a: assert property (!hit_c |=> !instr_hit)
        else $error("false hit");
    hit_write_a: assert property (instr_hit |=> acc_write)
        else $error("no write");
    write_cause_a: assert property (acc_write |-> $past(instr_hit))
        else $error("stray write");
    pass_through_a: assert property (
        !hit_c ##1 1'b1 |=> !acc_write && acc_out == $past(acc_in))
        else $error("pass wrong");
    flags_zero_a: assert property (!carry_write && !skip_write)
        else $error("flag write");
endmodule

// file: tb/rtar_decoder_tb.sv
// Purpose: self-checking bench for the accumulator read decoder
// Assumes: inputs driven on the falling edge
// Notes:   random words mixed with the eight read opcodes
`timescale 1ns/100ps
module rtar_decoder_tb
    import rtar_pkg::*;
;
    localparam logic [IW-1:0] OPS [SRC_CNT] = '{OP_READ_CLOCK_CONTROL,
        OP_READ_RESISTOR_GROUP_ZERO, OP_READ_RESISTOR_GROUP_ONE,
        OP_READ_CONVERTER_CONTROL_ONE, OP_READ_CONVERTER_CONTROL_TWO,
        OP_READ_CONVERTER_CONTROL_THREE, OP_READ_STACK_POINTER,
        OP_READ_INTERRUPT_ENABLE_ONE};
    logic          clk, rst = 1'b1, instr_valid = 1'b0;
    logic [IW-1:0] instr_word = '0;
    logic [DW-1:0] acc_in = '0, src [SRC_CNT] = '{default: '0};
    logic [DW-1:0] acc_out, m_acc, p_src;
    logic          acc_write, instr_hit, carry_write, skip_write, m_hit, m_wr;
    logic          m_idle;
    logic [DW:0]   e;
    int            errors = 0, compares = 0;
    rtar_decoder dut (.clk, .rst, .instr_valid, .instr_word, .acc_in,
        .clock_control_register(src[0]), .resistor_enable_group_zero(src[1]),
        .resistor_enable_group_one(src[2]), .converter_control_one(src[3]),
        .converter_control_two(src[4]), .converter_control_three(src[5]),
        .stack_pointer(src[6][SPW-1:0]), .interrupt_enable_one(src[7]),
        .acc_out, .acc_write, .instr_hit, .carry_write, .skip_write);
    function automatic logic [DW:0] exp_of(logic v, logic [IW-1:0] w);
        for (int i = 0; i < SRC_CNT; i++)
            if (v && w == OPS[i])
                return {1'b1, i == int'(SEL_SP) ?
                    {SP_PAD, src[i][SPW-1:0]} : src[i]};
        return {1'b0, SRC_NONE};
    endfunction
    always @(posedge clk) begin
        e = exp_of(instr_valid, instr_word);
        m_hit <= !rst && e[DW];
        m_wr <= !rst && m_hit;
        p_src <= e[DW-1:0];
        m_acc <= rst ? ACC_RESET : (m_hit ? p_src :
            ((m_idle && e[DW]) ? m_acc : acc_in));
        m_idle <= rst;
    end
    task automatic chk(logic [DW-1:0] got, logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(logic r, logic v, logic [IW-1:0] w);
        @(negedge clk);
        chk(acc_out, m_acc);
        chk({3'h0, acc_write}, {3'h0, m_wr});
        chk({3'h0, instr_hit}, {3'h0, m_hit});
        chk({2'h0, carry_write, skip_write}, 4'h0);
        rst = r;
        instr_valid = v;
        instr_word = w;
        acc_in = DW'($urandom);
        foreach (src[i]) src[i] = DW'($urandom);
    endtask
    task print_verdict;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        errors++;
        print_verdict;
    end
    initial begin
        void'($urandom(7967));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        foreach (OPS[i]) step(1'b0, 1'b1, OPS[i]);
        step(1'b0, 1'b0, OPS[0]);
        step(1'b0, 1'b1, OPS[6] ^ 10'h200);
        step(1'b1, 1'b1, OPS[3]);
        step(1'b0, 1'b1, OPS[0]);
        repeat (2000) step(1'b0, 1'($urandom), $urandom_range(1) ?
            OPS[$urandom_range(7)] : IW'($urandom));
        repeat (2) step(1'b0, 1'b0, '0);
        print_verdict;
    end
endmodule
bind rtar_decoder rtar_checker chk_i (.clk, .rst, .instr_valid, .instr_word,
    .acc_in, .clock_control_register, .stack_pointer, .acc_out, .acc_write,
    .instr_hit, .carry_write, .skip_write);
